// File: hw/mmp_defines.svh
/*
 * Constants of the PHY-facing port: system clock, management clock timing,
 * management frame layout. Assumes inclusion by the management master and the port.
 */
`ifndef MMP_DEFINES_SVH
`define MMP_DEFINES_SVH
`define MMP_CLK_NS 10
`define MMP_MDC_HALF_NS 200
`define MMP_MDC_HALF_CYC ((`MMP_MDC_HALF_NS + `MMP_CLK_NS - 1) / `MMP_CLK_NS)
`define MMP_RX_DEPTH 8
`define MMP_MD_BITS 64
`define MMP_MD_LAST 6'h3F
`define MMP_MD_TA 6'h2E
`define MMP_MD_DATA 6'h30
`define MMP_MD_PRE 32'hFFFFFFFF
`define MMP_MD_ST 2'h1
`define MMP_MD_OP_RD 2'h2
`define MMP_MD_OP_WR 2'h1
`define MMP_MD_TA_WR 2'h2
`define MMP_MD_TA_RD 2'h0
`endif

// File: hw/mmp_pkg.sv
/*
 * Types shared by the PHY-facing port and its submodules.
 * Assumes the defines header is available on the include path.
 */
package mmp_pkg;
   typedef struct packed {
      logic [7:0] data;
      logic err;
      logic last;
   } mmp_rx_word_t;
   typedef struct packed {
      logic rd;
      logic [4:0] phy;
      logic [4:0] regad;
      logic [15:0] wdata;
   } mmp_md_cmd_t;
endpackage : mmp_pkg

// File: hw/mmp_fifo.sv
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module mmp_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   import mmp_pkg::*;
   localparam int AW = $clog2(DEPTH);
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH)
      begin : g_chk
         $error("FIFO depth must be a power of two of at least two.");
      end
   endgenerate
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic push, pop;
   always_comb
   begin
      o_in_ready = (wr_r - rd_r) != (AW + 1)'(DEPTH);
      o_out_valid = wr_r != rd_r;
      o_out_data = mem_r[rd_r[AW-1:0]];
      push = i_in_valid & o_in_ready;
      pop = o_out_valid & i_out_ready;
      wr_nxt = wr_r + (AW + 1)'(push);
      rd_nxt = rd_r + (AW + 1)'(pop);
   end
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         wr_r <= '0;
         rd_r <= '0;
      end
      else
      begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
      if (push)
      begin
         mem_r[wr_r[AW-1:0]] <= i_in_data;
      end
   end
endmodule : mmp_fifo

// File: hw/mmp_mdio.sv
/*
 * Management interface master: makes the management clock and runs one
 * read or write frame per start. Assumes an external pull-up on the data line.
 */
`timescale 1ns/1ps
`include "mmp_defines.svh"
module mmp_mdio #(
   parameter int MDC_HALF = `MMP_MDC_HALF_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_start,
   input wire mmp_pkg::mmp_md_cmd_t i_cmd,
   input wire logic i_mdio_in,
   output logic o_mdc,
   output logic o_mdio_out,
   output logic o_mdio_oe,
   output logic o_busy,
   output logic o_done,
   output logic [15:0] o_rdata
);
   import mmp_pkg::*;
   localparam int TW = $clog2(MDC_HALF + 1);
   generate
      if (MDC_HALF < 1)
      begin : g_chk
         $error("Management clock half period must be at least one cycle.");
      end
   endgenerate
   logic [`MMP_MD_BITS-1:0] shf_r, shf_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic [TW-1:0] tmr_r, tmr_nxt;
   logic mdc_r, mdc_nxt, mdo_r, mdo_nxt, oe_r, oe_nxt;
   logic busy_r, busy_nxt, done_r, done_nxt, rd_r, rd_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic mdi_s1_r, mdi_s2_r;
   always_comb
   begin
      shf_nxt = shf_r;
      cnt_nxt = cnt_r;
      tmr_nxt = tmr_r;
      mdc_nxt = mdc_r;
      mdo_nxt = mdo_r;
      oe_nxt = oe_r;
      busy_nxt = busy_r;
      rd_nxt = rd_r;
      rdata_nxt = rdata_r;
      done_nxt = 1'b0;
      if (!busy_r)
      begin
         if (i_start)
         begin
            shf_nxt = {`MMP_MD_PRE, `MMP_MD_ST,
                       i_cmd.rd ? `MMP_MD_OP_RD : `MMP_MD_OP_WR, i_cmd.phy, i_cmd.regad,
                       i_cmd.rd ? `MMP_MD_TA_RD : `MMP_MD_TA_WR, i_cmd.wdata};
            mdo_nxt = shf_nxt[`MMP_MD_BITS-1];
            oe_nxt = 1'b1;
            busy_nxt = 1'b1;
            rd_nxt = i_cmd.rd;
            cnt_nxt = '0;
            tmr_nxt = TW'(MDC_HALF - 1);
         end
      end
      else if (tmr_r != '0)
      begin
         tmr_nxt = tmr_r - 1'b1;
      end
      else
      begin
         tmr_nxt = TW'(MDC_HALF - 1);
         mdc_nxt = ~mdc_r;
         if (!mdc_r && rd_r && cnt_r >= `MMP_MD_DATA)
         begin
            rdata_nxt = {rdata_r[14:0], mdi_s2_r};
         end
         if (mdc_r)
         begin
            if (cnt_r == `MMP_MD_LAST)
            begin
               busy_nxt = 1'b0;
               oe_nxt = 1'b0;
               done_nxt = 1'b1;
            end
            else
            begin
               cnt_nxt = cnt_r + 1'b1;
               shf_nxt = {shf_r[`MMP_MD_BITS-2:0], 1'b0};
               mdo_nxt = shf_nxt[`MMP_MD_BITS-1];
               oe_nxt = !(rd_r && cnt_nxt >= `MMP_MD_TA);
            end
         end
      end
   end
   always_ff @(posedge i_clk)
   begin
      mdi_s1_r <= i_mdio_in;
      mdi_s2_r <= mdi_s1_r;
      if (i_reset)
      begin
         shf_r <= '0;
         cnt_r <= '0;
         tmr_r <= '0;
         mdc_r <= 1'b0;
         mdo_r <= 1'b1;
         oe_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         rd_r <= 1'b0;
         rdata_r <= '0;
      end
      else
      begin
         shf_r <= shf_nxt;
         cnt_r <= cnt_nxt;
         tmr_r <= tmr_nxt;
         mdc_r <= mdc_nxt;
         mdo_r <= mdo_nxt;
         oe_r <= oe_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         rd_r <= rd_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   assign o_mdc = mdc_r;
   assign o_mdio_out = mdo_r;
   assign o_mdio_oe = oe_r;
   assign o_busy = busy_r;
   assign o_done = done_r;
   assign o_rdata = rdata_r;
endmodule : mmp_mdio

// File: hw/mmp_port.sv
/*
 * Media-independent port of an Ethernet MAC toward an external PHY: receive
 * and transmit nibble paths, collision and carrier status, management master.
 * Assumes the PHY clocks are far slower than I_CLK and are sampled as inputs.
 */
// Summary of operation
// - Take receive nibble only while receive-valid high.
// - Drive transmit nibble with transmit-enable on clock.
// - Receive error counts only at 100 Mb/s.
// - Collision input reported as collision detection.
// - Alternate pin gives carrier sense, half duplex.
// - Device generates management clock for transfers.
// - Writes drive management data toward the PHY.
// - Reads capture PHY data from shared line.
`timescale 1ns/1ps
`include "mmp_defines.svh"
module mmp_port #(
   parameter int RX_DEPTH = `MMP_RX_DEPTH,
   parameter int MDC_HALF = `MMP_MDC_HALF_CYC
) (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire logic I_PHY_RECEIVE_CLOCK,
   input wire logic [3:0] I_RXD,
   input wire logic I_RECEIVE_VALID,
   input wire logic I_RECEIVE_ERROR_IN,
   input wire logic I_PHY_TRANSMIT_CLOCK,
   input wire logic I_COL,
   input wire logic I_CARRIER_SENSE_ALT_PIN,
   input wire logic I_MDIO_IN,
   input wire logic I_SPEED_100,
   input wire logic I_HALF_DUPLEX,
   input wire logic I_CRS_ALT_SEL,
   input wire logic I_RX_READY,
   input wire logic I_TX_VALID,
   input wire logic [7:0] I_TX_DATA,
   input wire logic I_TX_LAST,
   input wire logic I_MD_START,
   input wire mmp_pkg::mmp_md_cmd_t I_MD_CMD,
   output logic O_RX_VALID,
   output logic [7:0] O_RX_DATA,
   output logic O_RX_ERROR,
   output logic O_RX_LAST,
   output logic O_RX_OVERFLOW,
   output logic O_TX_READY,
   output logic [3:0] O_TXD,
   output logic O_TRANSMIT_ENABLE_OUT,
   output logic O_COLLISION,
   output logic O_CARRIER,
   output logic O_MDC,
   output logic O_MDIO_OUT,
   output logic O_MDIO_OE,
   output logic O_MD_BUSY,
   output logic O_MD_DONE,
   output logic [15:0] O_MD_RDATA
);
   import mmp_pkg::*;
   generate
      if (RX_DEPTH < 2)
      begin : g_chk
         $error("Receive buffer needs at least two words.");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic rise(input logic prev, input logic cur);
      rise = cur & ~prev;
   endfunction : rise

   function automatic logic [3:0] nib(input logic [7:0] b, input logic hi);
      nib = hi ? b[7:4] : b[3:0];
   endfunction : nib

   ////////////////////////////////////////////////////////////////////////////
   // Every PHY pin passes two flops; a third flop on each clock feeds the
   // edge finder so that the first stage is read by nothing but the second.
   logic [9:0] pin_s1_r, pin_s2_r;
   logic rxc_s3_r, txc_s3_r;
   logic rx_edge, tx_edge;
   logic [3:0] rxd_s;
   logic rxdv_s, rxer_s, col_s, crs_s;
   always_ff @(posedge I_CLK)
   begin
      pin_s1_r <= {I_PHY_RECEIVE_CLOCK, I_PHY_TRANSMIT_CLOCK, I_RXD, I_RECEIVE_VALID,
                   I_RECEIVE_ERROR_IN, I_COL, I_CARRIER_SENSE_ALT_PIN};
      pin_s2_r <= pin_s1_r;
      rxc_s3_r <= pin_s2_r[9];
      txc_s3_r <= pin_s2_r[8];
   end
   always_comb
   begin
      {rxd_s, rxdv_s, rxer_s, col_s, crs_s} = pin_s2_r[7:0];
      rx_edge = rise(rxc_s3_r, pin_s2_r[9]);
      tx_edge = rise(txc_s3_r, pin_s2_r[8]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive assembly: low nibble first. A byte is held back one step so
   // that the frame end, seen only when receive-valid falls, can mark it last.
   logic [3:0] lo_r, lo_nxt;
   logic half_r, half_nxt, dvp_r, dvp_nxt, eacc_r, eacc_nxt;
   mmp_rx_word_t pend_r, pend_nxt, push_w;
   logic pendv_r, pendv_nxt, push, in_ready, ovf_r, ovf_nxt, er_100;
   always_comb
   begin
      lo_nxt = lo_r;
      half_nxt = half_r;
      eacc_nxt = eacc_r;
      pend_nxt = pend_r;
      pendv_nxt = pendv_r;
      dvp_nxt = dvp_r;
      push = 1'b0;
      push_w = pend_r;
      er_100 = rxer_s & I_SPEED_100;
      if (rx_edge)
      begin
         dvp_nxt = rxdv_s;
         if (rxdv_s)
         begin
            if (!half_r)
            begin
               lo_nxt = rxd_s;
               half_nxt = 1'b1;
               eacc_nxt = eacc_r | er_100;
            end
            else
            begin
               half_nxt = 1'b0;
               push = pendv_r;
               push_w.last = 1'b0;
               pend_nxt.data = {rxd_s, lo_r};
               pend_nxt.err = eacc_r | er_100;
               pend_nxt.last = 1'b0;
               pendv_nxt = 1'b1;
               eacc_nxt = 1'b0;
            end
         end
         else if (dvp_r)
         begin
            // A trailing odd nibble is dropped and the last byte flagged.
            push = pendv_r;
            push_w.last = 1'b1;
            push_w.err = pend_r.err | half_r;
            pendv_nxt = 1'b0;
            half_nxt = 1'b0;
            eacc_nxt = 1'b0;
         end
      end
      // The PHY cannot be stalled, so a full buffer loses the byte.
      ovf_nxt = push & ~in_ready;
   end
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         lo_r <= '0;
         half_r <= 1'b0;
         eacc_r <= 1'b0;
         pend_r <= '0;
         pendv_r <= 1'b0;
         dvp_r <= 1'b0;
         ovf_r <= 1'b0;
      end
      else
      begin
         lo_r <= lo_nxt;
         half_r <= half_nxt;
         eacc_r <= eacc_nxt;
         pend_r <= pend_nxt;
         pendv_r <= pendv_nxt;
         dvp_r <= dvp_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic f_valid, f_pop;
   mmp_rx_word_t f_data, out_r, out_nxt;
   logic outv_r, outv_nxt;
   mmp_fifo #(
      .WIDTH($bits(mmp_rx_word_t)),
      .DEPTH(RX_DEPTH)
   ) u_rx_fifo (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_in_valid(push),
      .o_in_ready(in_ready),
      .i_in_data(push_w),
      .o_out_valid(f_valid),
      .i_out_ready(f_pop),
      .o_out_data(f_data)
   );
   always_comb
   begin
      f_pop = f_valid & (~outv_r | I_RX_READY);
      outv_nxt = outv_r & ~I_RX_READY;
      out_nxt = out_r;
      if (f_pop)
      begin
         outv_nxt = 1'b1;
         out_nxt = f_data;
      end
   end
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         outv_r <= 1'b0;
         out_r <= '0;
      end
      else
      begin
         outv_r <= outv_nxt;
         out_r <= out_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit: outputs change just after a sampled rising edge of the PHY
   // clock, giving nearly a full period of setup before the next one. This
   // relies on the PHY clock being well below a quarter of I_CLK.
   logic [7:0] tbyte_r, tbyte_nxt;
   logic thold_r, thold_nxt, thi_r, thi_nxt, tlast_r, tlast_nxt;
   logic tend_r, tend_nxt, trdy_r, trdy_nxt, ten_r, ten_nxt;
   logic [3:0] txd_r, txd_nxt;
   always_comb
   begin
      tbyte_nxt = tbyte_r;
      thold_nxt = thold_r;
      thi_nxt = thi_r;
      tlast_nxt = tlast_r;
      tend_nxt = tend_r;
      ten_nxt = ten_r;
      txd_nxt = txd_r;
      if (I_TX_VALID && trdy_r)
      begin
         tbyte_nxt = I_TX_DATA;
         tlast_nxt = I_TX_LAST;
         thold_nxt = 1'b1;
         thi_nxt = 1'b0;
      end
      if (tx_edge)
      begin
         if (thold_r && !tend_r)
         begin
            txd_nxt = nib(tbyte_r, thi_r);
            ten_nxt = 1'b1;
            thi_nxt = ~thi_r;
            if (thi_r)
            begin
               thold_nxt = 1'b0;
               tend_nxt = tlast_r;
            end
         end
         else
         begin
            // One idle clock separates frames after a last byte.
            ten_nxt = 1'b0;
            txd_nxt = '0;
            tend_nxt = 1'b0;
         end
      end
      trdy_nxt = ~thold_nxt;
   end
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         tbyte_r <= '0;
         thold_r <= 1'b0;
         thi_r <= 1'b0;
         tlast_r <= 1'b0;
         tend_r <= 1'b0;
         ten_r <= 1'b0;
         txd_r <= '0;
         trdy_r <= 1'b0;
      end
      else
      begin
         tbyte_r <= tbyte_nxt;
         thold_r <= thold_nxt;
         thi_r <= thi_nxt;
         tlast_r <= tlast_nxt;
         tend_r <= tend_nxt;
         ten_r <= ten_nxt;
         txd_r <= txd_nxt;
         trdy_r <= trdy_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic col_r, col_nxt, crs_r, crs_nxt;
   always_comb
   begin
      col_nxt = col_s;
      crs_nxt = crs_s & I_CRS_ALT_SEL & I_HALF_DUPLEX;
   end
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         col_r <= 1'b0;
         crs_r <= 1'b0;
      end
      else
      begin
         col_r <= col_nxt;
         crs_r <= crs_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   mmp_mdio #(
      .MDC_HALF(MDC_HALF)
   ) u_mdio (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_start(I_MD_START),
      .i_cmd(I_MD_CMD),
      .i_mdio_in(I_MDIO_IN),
      .o_mdc(O_MDC),
      .o_mdio_out(O_MDIO_OUT),
      .o_mdio_oe(O_MDIO_OE),
      .o_busy(O_MD_BUSY),
      .o_done(O_MD_DONE),
      .o_rdata(O_MD_RDATA)
   );

   assign O_RX_VALID = outv_r;
   assign O_RX_DATA = out_r.data;
   assign O_RX_ERROR = out_r.err;
   assign O_RX_LAST = out_r.last;
   assign O_RX_OVERFLOW = ovf_r;
   assign O_TX_READY = trdy_r;
   assign O_TXD = txd_r;
   assign O_TRANSMIT_ENABLE_OUT = ten_r;
   assign O_COLLISION = col_r;
   assign O_CARRIER = crs_r;
endmodule : mmp_port

// File: verification/mmp_port_assertions.sv
/*
 * Checker of the PHY port's top-level timing.
 * Assumes binding to mmp_port with the same MDC_HALF.
 */
`timescale 1ns/1ps
module mmp_port_assertions #(
   parameter int MDC_HALF = 20
) (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire logic I_COL,
   input wire logic I_CARRIER_SENSE_ALT_PIN,
   input wire logic I_HALF_DUPLEX,
   input wire logic I_CRS_ALT_SEL,
   input wire logic I_RX_READY,
   input wire logic I_TX_VALID,
   input wire logic I_MD_START,
   input wire logic O_RX_VALID,
   input wire logic [7:0] O_RX_DATA,
   input wire logic O_TX_READY,
   input wire logic O_COLLISION,
   input wire logic O_CARRIER,
   input wire logic O_MDC,
   input wire logic O_MDIO_OUT,
   input wire logic O_MDIO_OE,
   input wire logic O_MD_BUSY,
   input wire logic O_MD_DONE
);
   localparam int MD_CYC = 128 * MDC_HALF;
   logic [2:0] up_r, up_nxt;
   logic [15:0] hi_r, hi_nxt, bz_r, bz_nxt;
   // Synchronised inputs are only valid three edges after reset.
   always_comb
   begin
      up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
      hi_nxt = O_MDC ? hi_r + 16'h0001 : 16'h0000;
      bz_nxt = O_MD_BUSY ? bz_r + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         up_r <= 3'h0;
         hi_r <= 16'h0000;
         bz_r <= 16'h0000;
      end
      else
      begin
         up_r <= up_nxt;
         hi_r <= hi_nxt;
         bz_r <= bz_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RESET);
   sequence s_md_take;
      I_MD_START && !O_MD_BUSY;
   endsequence
   sequence s_md_run;
      O_MD_BUSY && O_MDIO_OE && O_MDIO_OUT;
   endsequence
   sequence s_crs_mode;
      I_CRS_ALT_SEL && I_HALF_DUPLEX;
   endsequence
   property p_md_start;
      s_md_take |=> s_md_run;
   endproperty
   property p_col;
      (up_r > 3'h3) |-> O_COLLISION == $past(I_COL, 3);
   endproperty
   property p_crs_on;
      s_crs_mode [*4] |-> O_CARRIER == $past(I_CARRIER_SENSE_ALT_PIN, 3);
   endproperty
   property p_crs_off;
      (!I_CRS_ALT_SEL) [*2] |-> !O_CARRIER;
   endproperty
   property p_mdc_idle;
      !O_MD_BUSY |-> !O_MDC;
   endproperty
   property p_mdc_half;
      $fell(O_MDC) |-> hi_r == MDC_HALF;
   endproperty
   property p_md_len;
      $rose(O_MD_DONE) |-> (bz_r >= MD_CYC - 1) && (bz_r <= MD_CYC + 1);
   endproperty
   property p_md_done;
      O_MD_DONE |-> !O_MD_BUSY ##1 !O_MD_DONE;
   endproperty
   property p_md_oe;
      O_MDIO_OE |-> O_MD_BUSY;
   endproperty
   property p_rx_stand;
      O_RX_VALID && !I_RX_READY |=> O_RX_VALID && $stable(O_RX_DATA);
   endproperty
   property p_tx_take;
      I_TX_VALID && O_TX_READY |=> !O_TX_READY;
   endproperty
   a_md_start: assert property (p_md_start) else $error("start not taken");
   a_col: assert property (p_col) else $error("collision not reported");
   a_crs_on: assert property (p_crs_on) else $error("carrier not followed");
   a_crs_off: assert property (p_crs_off) else $error("carrier while unselected");
   a_mdc_idle: assert property (p_mdc_idle) else $error("clock runs while idle");
   a_mdc_half: assert property (p_mdc_half) else $error("clock half period wrong");
   a_md_len: assert property (p_md_len) else $error("frame length wrong");
   a_md_done: assert property (p_md_done) else $error("done not a pulse");
   a_md_oe: assert property (p_md_oe) else $error("line driven while idle");
   a_rx_stand: assert property (p_rx_stand) else $error("receive word moved");
   a_tx_take: assert property (p_tx_take) else $error("byte not taken");
endmodule : mmp_port_assertions

// File: verification/mmp_phy_model.sv
/*
 * Behavioural PHY: link clocks, receive nibbles, management responder.
 * Assumes the bench resolves the shared data line.
 */
`timescale 1ns/1ps
module mmp_phy_model (
   input wire logic i_mdc,
   input wire logic i_mdio,
   input wire logic i_tx_run,
   input wire logic [15:0] i_rd_value,
   output logic o_rx_clk,
   output logic [3:0] o_rxd,
   output logic o_rx_dv,
   output logic o_rx_er,
   output logic o_tx_clk,
   output logic o_mdio_out,
   output logic o_mdio_oe,
   output logic [63:0] o_frame
);
   localparam realtime HALF = 62.5;
   int cnt = 0;
   logic rd_op = 1'b0;
   initial
   begin
      {o_rx_clk, o_rxd, o_rx_dv, o_rx_er, o_tx_clk} = '0;
      o_mdio_out = 1'b1;
      {o_mdio_oe, o_frame} = '0;
   end
   // The transmit clock stands still between frames, so the port must not rely on it.
   always
   begin
      #HALF;
      if (i_tx_run || o_tx_clk)
         o_tx_clk = ~o_tx_clk;
   end
   task automatic rx_nibble(input logic [3:0] d, input logic dv, input logic er);
      o_rxd = d;
      o_rx_dv = dv;
      o_rx_er = er;
      #HALF o_rx_clk = 1'b1;
      #HALF o_rx_clk = 1'b0;
   endtask : rx_nibble
   task automatic rx_frame(input logic [7:0] b[16], input int n, input logic er);
      for (int i = 0; i < n; i++)
      begin
         rx_nibble(b[i][3:0], 1'b1, er);
         rx_nibble(b[i][7:4], 1'b1, er);
      end
      rx_nibble(~o_rxd, 1'b0, 1'b0);
      o_rxd = ~o_rxd;
   endtask : rx_frame
   always @(posedge i_mdc)
   begin
      o_frame = {o_frame[62:0], i_mdio};
      cnt = cnt + 1;
   end
   // Bits change on the falling edge so they are settled at the next rising edge.
   always @(negedge i_mdc)
   begin
      if (cnt == 36)
         rd_op = (o_frame[1:0] == 2'b10);
      o_mdio_oe = rd_op && cnt >= 47 && cnt <= 63;
      o_mdio_out = (cnt >= 48 && cnt <= 63) ? i_rd_value[63 - cnt] : 1'b0;
      if (cnt == 64)
         cnt = 0;
   end
endmodule : mmp_phy_model

// File: verification/tb_mmp_port.sv
/*
 * Self-checking bench of the PHY port beside a behavioural PHY.
 * Assumes the package and the checker are compiled first.
 */
`timescale 1ns/1ps
module tb_mmp_port;
   import mmp_pkg::*;
   localparam int MDC_HALF = 4;
   logic I_CLK, I_RESET, I_PHY_RECEIVE_CLOCK, I_RECEIVE_VALID, I_RECEIVE_ERROR_IN;
   logic I_PHY_TRANSMIT_CLOCK, I_COL, I_CARRIER_SENSE_ALT_PIN, I_SPEED_100, I_HALF_DUPLEX;
   logic I_CRS_ALT_SEL, I_RX_READY, I_TX_VALID, I_TX_LAST, I_MD_START;
   logic [3:0] I_RXD;
   logic [7:0] I_TX_DATA;
   mmp_md_cmd_t I_MD_CMD;
   logic O_RX_VALID, O_RX_ERROR, O_RX_LAST, O_RX_OVERFLOW, O_TX_READY, O_TRANSMIT_ENABLE_OUT;
   logic O_COLLISION, O_CARRIER, O_MDC, O_MDIO_OUT, O_MDIO_OE, O_MD_BUSY, O_MD_DONE;
   logic [7:0] O_RX_DATA;
   logic [3:0] O_TXD;
   logic [15:0] O_MD_RDATA, rd_value;
   logic [63:0] frame;
   logic [80:0] md_e;
   logic [7:0] lfsr_r, rnd;
   logic rx_hold, tx_run, phy_out, phy_oe, mdio_w;
   int n_errors, n_compared, n_ovf;
   logic [9:0] rx_q[$];
   logic [3:0] tx_q[$];
   logic [80:0] md_q[$];
   assign mdio_w = O_MDIO_OE ? O_MDIO_OUT : (phy_oe ? phy_out : 1'b1);
   mmp_port #(.MDC_HALF(MDC_HALF)) DUT (.*, .I_MDIO_IN(mdio_w));
   mmp_phy_model PHY (.i_mdc(O_MDC), .i_mdio(mdio_w), .i_tx_run(tx_run),
      .i_rd_value(rd_value), .o_rx_clk(I_PHY_RECEIVE_CLOCK), .o_rxd(I_RXD),
      .o_rx_dv(I_RECEIVE_VALID), .o_rx_er(I_RECEIVE_ERROR_IN),
      .o_tx_clk(I_PHY_TRANSMIT_CLOCK), .o_mdio_out(phy_out), .o_mdio_oe(phy_oe),
      .o_frame(frame));
   ////////////////////////////////////////////////////////////////////////////////////////////
   always #5 I_CLK = ~I_CLK;
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next
   task automatic check(input logic [80:0] seen, input logic [80:0] exp, input string what);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check
   always @(posedge I_CLK)
   begin
      lfsr_r <= lfsr_next(lfsr_r);
      I_RX_READY <= !rx_hold && lfsr_r[0];
      I_COL <= lfsr_r[3] && lfsr_r[6];
      I_CARRIER_SENSE_ALT_PIN <= lfsr_r[1];
      if (O_RX_OVERFLOW === 1'b1)
         n_ovf++;
      if (O_RX_VALID === 1'b1 && I_RX_READY === 1'b1)
         check({O_RX_DATA, O_RX_ERROR, O_RX_LAST}, rx_q.size() ? rx_q.pop_front() : 'x,
            "receive word");
      if (O_MD_DONE !== 1'b0 && !I_RESET)
      begin
         md_e = md_q.size() ? md_q.pop_front() : 'x;
         check(frame, md_e[63:0], "management frame");
         if (md_e[80])
            check(O_MD_RDATA, md_e[79:64], "read data");
      end
   end
   always @(posedge I_PHY_TRANSMIT_CLOCK)
      if (O_TRANSMIT_ENABLE_OUT !== 1'b0)
         check(O_TXD, tx_q.size() ? tx_q.pop_front() : 'x, "transmit nibble");
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic rx_test(input int n, input logic spd, input logic er, input logic hold);
      logic [7:0] b[16];
      mmp_rx_word_t w;
      @(posedge I_CLK);
      I_SPEED_100 <= spd;
      rx_hold <= hold;
      for (int i = 0; i < n; i++)
      begin
         rnd = lfsr_next(rnd);
         b[i] = rnd;
         w = '{data: rnd, err: er && spd, last: i == n - 1};
         // Eight buffered words plus the output register hold nine bytes.
         if (!hold || i < 9)
            rx_q.push_back(w);
      end
      PHY.rx_frame(b, n, er);
      repeat (10) @(posedge I_CLK);
      rx_hold <= 1'b0;
      for (int k = 0; k < 3000 && rx_q.size() != 0; k++)
         @(posedge I_CLK);
      check(rx_q.size(), 0, "receive backlog");
      if (hold)
         check(n_ovf, 1, "overflow count");
      $display("test receive done");
   endtask : rx_test
   task automatic tx_test(input int n);
      @(posedge I_CLK);
      tx_run <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         rnd = lfsr_next(rnd);
         tx_q.push_back(rnd[3:0]);
         tx_q.push_back(rnd[7:4]);
         I_TX_VALID <= 1'b1;
         I_TX_DATA <= rnd;
         I_TX_LAST <= (i == n - 1);
         @(posedge I_CLK);
         for (int k = 0; k < 300 && O_TX_READY !== 1'b1; k++)
            @(posedge I_CLK);
      end
      I_TX_VALID <= 1'b0;
      repeat (200) @(posedge I_CLK);
      tx_run <= 1'b0;
      check(tx_q.size(), 0, "transmit backlog");
      check(O_TRANSMIT_ENABLE_OUT, 1'b0, "enable after frame");
      $display("test transmit done");
   endtask : tx_test
   task automatic md_op(input logic rd);
      mmp_md_cmd_t c;
      rnd = lfsr_next(rnd);
      c = '{rd: rd, phy: rnd[4:0], regad: rnd[7:3], wdata: {rnd, ~rnd}};
      rd_value = {~rnd, rnd};
      md_q.push_back({rd, rd_value, 32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, c.phy, c.regad,
         2'b10, rd ? rd_value : c.wdata});
      @(posedge I_CLK);
      I_MD_CMD <= c;
      I_MD_START <= 1'b1;
      // Start is held while busy on purpose: those requests must be ignored.
      repeat (3) @(posedge I_CLK);
      I_MD_START <= 1'b0;
      for (int k = 0; k < 2000 && O_MD_DONE !== 1'b1; k++)
         @(posedge I_CLK);
      @(posedge I_CLK);
      check(md_q.size(), 0, "management backlog");
      $display("test management done");
   endtask : md_op
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {I_CLK, I_SPEED_100, I_HALF_DUPLEX, I_CRS_ALT_SEL, I_RX_READY, I_COL} = '0;
      {I_TX_VALID, I_TX_LAST, I_MD_START, I_CARRIER_SENSE_ALT_PIN, rx_hold, tx_run} = '0;
      I_RESET = 1'b1;
      I_TX_DATA = 8'h00;
      I_MD_CMD = '0;
      rd_value = 16'h0000;
      lfsr_r = 8'h12;
      rnd = 8'h12;
      repeat (5) @(posedge I_CLK);
      I_RESET <= 1'b0;
      repeat (3) @(posedge I_CLK);
      for (int m = 0; m < 4; m++)
      begin
         I_CRS_ALT_SEL <= m[0];
         I_HALF_DUPLEX <= m[1];
         repeat (40) @(posedge I_CLK);
         if (m != 3)
            check(O_CARRIER, 1'b0, "carrier unselected");
      end
      rx_test(6, 1'b0, 1'b1, 1'b0);
      rx_test(5, 1'b1, 1'b1, 1'b0);
      rx_test(4, 1'b1, 1'b0, 1'b0);
      rx_test(10, 1'b1, 1'b0, 1'b1);
      tx_test(6);
      md_op(1'b0);
      md_op(1'b1);
      md_op(1'b1);
      report_and_stop();
   end
   // Tests take about 30 us; over six times that is a hang.
   initial
   begin
      #200000;
      n_errors++;
      report_and_stop();
   end
endmodule : tb_mmp_port
bind mmp_port mmp_port_assertions #(.MDC_HALF(MDC_HALF)) u_chk (.*);
